// ---- hdl/dsr_self_refresh_control.sv ----
// Self-refresh sequencer for a DDR3 memory controller.
// Assumes the command path holds requests until cmd_grant_o and reports completion.
//
// How it works
// RQ1: Low-power select 0x2 lets the controller put memory into self-refresh.
// RQ2: Pending read or write in self-refresh causes exit, then commands run.
// RQ3: After commands finish, wait the idle delay before re-entering self-refresh.
// RQ4: One refresh issued on each self-refresh entry and one on each exit.
// RQ5: Idle delay 0x9 or more waits at least 4096 idle cycles.
// RQ6: At most 16 refreshes reach memory within any two refresh intervals.
// RQ7: Software using mode 0x2 should set idle delay to 0x9 or more.
// RQ8: Repeated entry/exit cycles must not push refreshes past the limit.
// RQ9: Refreshes are held back until the sliding-window count is below limit.
`timescale 1ns/1ps
module dsr_self_refresh_control
  import dsr_pkg::*;
#(
  parameter int SAFE_IDLE_CYC = DSR_SAFE_IDLE_CYC
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [2:0] low_power_select_i,
  input wire logic [3:0] self_refresh_idle_delay_i,
  input wire logic cmd_pending_i,
  input wire logic cmd_busy_i,
  output logic cmd_grant_o,
  output logic refresh_cmd_o,
  output logic sr_enter_o,
  output logic sr_exit_o,
  output logic in_self_refresh_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    dsr_state_t state;
    logic [DSR_CNT_W-1:0] idle_cnt;
    logic grant;
    logic refresh;
    logic enter;
    logic leave;
    logic in_sr;
  } dsr_ctl_state_t;

  dsr_ctl_state_t s;
  dsr_ctl_state_t next_s;
  dsr_refresh_if ref_if();

  // Idle target: doubling per step from 8 cycles; codes at or above 0x9 reach the safe length
  function automatic logic [DSR_CNT_W-1:0] idle_target(input logic [3:0] code);
    logic [DSR_CNT_W-1:0] t;
    t = DSR_CNT_W'(8) << code;
    if (code >= DSR_IDLE_DELAY_SAFE) begin
      t = DSR_CNT_W'(SAFE_IDLE_CYC - 1);
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.refresh = 1'b0;
    next_s.enter = 1'b0;
    next_s.leave = 1'b0;
    next_s.grant = 1'b0;
    ref_if.issue = 1'b0;
    unique case (s.state)
      DSR_ACTIVE: begin
        // Grant commands only while awake, see RQ2
        next_s.grant = cmd_pending_i;
        next_s.idle_cnt = '0;
        if (!cmd_pending_i && !cmd_busy_i && low_power_select_i == DSR_LP_SELF_REFRESH) begin
          next_s.state = DSR_IDLE_WAIT;
        end
      end
      DSR_IDLE_WAIT: begin
        // Any new activity restarts the idle count, see RQ3
        if (cmd_pending_i || cmd_busy_i || low_power_select_i != DSR_LP_SELF_REFRESH) begin
          next_s.state = DSR_ACTIVE;
        end else if (s.idle_cnt >= idle_target(self_refresh_idle_delay_i)) begin
          next_s.state = DSR_ENTER_REF; // see RQ5
        end else begin
          next_s.idle_cnt = s.idle_cnt + DSR_CNT_W'(1);
        end
      end
      DSR_ENTER_REF: begin
        // A command or mode change while waiting drops the entry instead of burning two refreshes
        if (cmd_pending_i || cmd_busy_i || low_power_select_i != DSR_LP_SELF_REFRESH) begin
          next_s.state = DSR_ACTIVE; // see RQ1 RQ2
        end else if (ref_if.allow) begin
          // Entry waits for room in the refresh window, see RQ8
          ref_if.issue = 1'b1;
          next_s.refresh = 1'b1; // see RQ4
          next_s.enter = 1'b1;
          next_s.in_sr = 1'b1; // see RQ1
          next_s.state = DSR_IN_SR;
        end
      end
      DSR_IN_SR: begin
        if (cmd_pending_i || low_power_select_i != DSR_LP_SELF_REFRESH) begin
          next_s.state = DSR_EXIT_REF;
        end
      end
      DSR_EXIT_REF: begin
        // Exit refresh is also paced; commands stay held meanwhile, see RQ9
        if (ref_if.allow) begin
          ref_if.issue = 1'b1;
          next_s.refresh = 1'b1; // see RQ4
          next_s.leave = 1'b1;
          next_s.in_sr = 1'b0;
          next_s.state = DSR_ACTIVE; // see RQ2
        end
      end
      default: begin
        next_s.state = DSR_ACTIVE;
        next_s.in_sr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh count window shared by entry and exit, see RQ6
  dsr_rate_limiter u_limiter (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ref_if(ref_if)
  );

  assign cmd_grant_o = s.grant;
  assign refresh_cmd_o = s.refresh;
  assign sr_enter_o = s.enter;
  assign sr_exit_o = s.leave;
  assign in_self_refresh_o = s.in_sr;

endmodule

// ---- hdl/dsr_pkg.sv ----
// Package for the DDR3 self-refresh control block: modes, states and timing constants.
// Assumes a 50 MHz controller clock; all counts are in cycles of that clock.
package dsr_pkg;

  localparam logic [2:0] DSR_LP_SELF_REFRESH = 3'h2;
  localparam logic [2:0] DSR_LP_RESET = 3'h0;
  localparam logic [3:0] DSR_IDLE_DELAY_RESET = 4'h9;
  localparam logic [3:0] DSR_IDLE_DELAY_SAFE = 4'h9;

  localparam int DSR_CLK_MHZ = 50;
  // One refresh interval, in nanoseconds
  localparam int DSR_TREFI_NS = 7800;
  // Sliding window of two refresh intervals, rounded down
  localparam int DSR_WINDOW_CYC = (2 * DSR_TREFI_NS * DSR_CLK_MHZ) / 1000;
  localparam int DSR_REF_LIMIT = 16;
  localparam int DSR_SAFE_IDLE_CYC = 4096;
  localparam int DSR_CNT_W = 13;

  // Width of the limiter's stored refresh count
  localparam int DSR_HIST_W = 5;

  typedef enum logic [2:0] {
    DSR_ACTIVE = 3'h0,
    DSR_IDLE_WAIT = 3'h1,
    DSR_ENTER_REF = 3'h3,
    DSR_IN_SR = 3'h2,
    DSR_EXIT_REF = 3'h6
  } dsr_state_t;

endpackage

// ---- hdl/dsr_refresh_if.sv ----
// Interface between the self-refresh sequencer and the refresh rate limiter.
// Assumes both ends run on the same controller clock.
`timescale 1ns/1ps
interface dsr_refresh_if;
  logic issue;
  logic allow;
  modport seq (output issue, input allow);
  modport lim (input issue, output allow);
endinterface

// ---- hdl/dsr_rate_limiter.sv ----
// Counts refresh commands in a sliding window of two refresh intervals.
// Assumes the sequencer only issues when allow is high.
`timescale 1ns/1ps
module dsr_rate_limiter
  import dsr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  dsr_refresh_if.lim ref_if
);

  typedef struct packed {
    logic [DSR_REF_LIMIT-1:0][DSR_CNT_W-1:0] age;
    logic [DSR_REF_LIMIT-1:0] live;
    logic [DSR_HIST_W-1:0] count;
  } dsr_lim_state_t;

  dsr_lim_state_t s;
  dsr_lim_state_t next_s;
  int slot;

  // Each live slot ages one issued refresh; it expires after the window length
  always_comb begin
    next_s = s;
    slot = DSR_REF_LIMIT;
    for (int i = 0; i < DSR_REF_LIMIT; i++) begin
      if (s.live[i]) begin
        if (s.age[i] == DSR_CNT_W'(DSR_WINDOW_CYC - 1)) begin
          next_s.live[i] = 1'b0;
          next_s.count = next_s.count - DSR_HIST_W'(1);
        end else begin
          next_s.age[i] = s.age[i] + DSR_CNT_W'(1);
        end
      end else if (slot == DSR_REF_LIMIT) begin
        slot = i;
      end
    end
    // Counting only ever admits a refresh into an empty slot; allow drops before a 16th, see RQ6
    if (ref_if.issue && slot < DSR_REF_LIMIT) begin
      next_s.live[slot] = 1'b1;
      next_s.age[slot] = '0;
      next_s.count = next_s.count + DSR_HIST_W'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // One slot of headroom held back: allow drops once 15 refreshes are live, see RQ9
  assign ref_if.allow = (s.count < DSR_HIST_W'(DSR_REF_LIMIT - 1));

endmodule

// ---- verification/dsr_ctl_asserts.sv ----
// Port checks for the self-refresh sequencer.
// Assumes one clock domain.
`timescale 1ns/1ps
module dsr_ctl_asserts
  import dsr_pkg::*;
#(parameter int SAFE_IDLE_CYC = DSR_SAFE_IDLE_CYC)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [2:0] low_power_select_i,
  input wire logic [3:0] self_refresh_idle_delay_i,
  input wire logic cmd_pending_i,
  input wire logic cmd_busy_i,
  input wire logic cmd_grant_o,
  input wire logic refresh_cmd_o,
  input wire logic sr_enter_o,
  input wire logic sr_exit_o,
  input wire logic in_self_refresh_o
);
  logic [DSR_WINDOW_CYC-1:0] hist;
  logic [4:0] win;
  logic [15:0] idle;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////
  // Window count drops the refresh leaving the history
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist <= '0;
      win <= '0;
      idle <= '0;
    end else begin
      hist <= {hist[DSR_WINDOW_CYC-2:0], refresh_cmd_o};
      win <= win + {4'h0, refresh_cmd_o} - {4'h0, hist[DSR_WINDOW_CYC-1]};
      if (cmd_pending_i || cmd_busy_i || in_self_refresh_o) idle <= '0;
      else if (idle != 16'hFFFF) idle <= idle + 16'h1;
    end
  end
  ////////////////////
  ref_on_entry_a: assert property (sr_enter_o |-> refresh_cmd_o && in_self_refresh_o)
    else $error("entry without refresh");
  ref_on_exit_a: assert property (sr_exit_o |-> refresh_cmd_o && !in_self_refresh_o)
    else $error("exit without refresh");
  ref_has_cause_a: assert property (refresh_cmd_o |-> sr_enter_o ^ sr_exit_o)
    else $error("stray refresh");
  entry_mode_a: assert property (sr_enter_o |-> $past(low_power_select_i) == DSR_LP_SELF_REFRESH)
    else $error("entry outside mode");
  entry_order_a: assert property (sr_enter_o |-> !$past(in_self_refresh_o))
    else $error("entry while in self-refresh");
  exit_grant_a: assert property (sr_exit_o && cmd_pending_i |=> cmd_grant_o)
    else $error("no grant after exit");
  no_sr_grant_a: assert property (in_self_refresh_o |-> !cmd_grant_o)
    else $error("grant in self-refresh");
  idle_delay_a: assert property (sr_enter_o |-> idle >= ((self_refresh_idle_delay_i >= DSR_IDLE_DELAY_SAFE) ?
    SAFE_IDLE_CYC : (8 << self_refresh_idle_delay_i))) else $error("entry too early");
  window_cap_a: assert property (win <= DSR_REF_LIMIT)
    else $error("too many refreshes in window");
endmodule
bind dsr_self_refresh_control dsr_ctl_asserts #(.SAFE_IDLE_CYC(SAFE_IDLE_CYC)) i_dsr_ctl_asserts (.clock_i,
  .rst_n_i, .low_power_select_i, .self_refresh_idle_delay_i, .cmd_pending_i, .cmd_busy_i, .cmd_grant_o,
  .refresh_cmd_o, .sr_enter_o, .sr_exit_o, .in_self_refresh_o);

// ---- verification/dsr_mem_model.sv ----
// Far side: runs granted commands and tracks the memory refresh state.
// Assumes busy_len_i is at least one.
`timescale 1ns/1ps
module dsr_mem_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic grant_i,
  input wire logic enter_i,
  input wire logic exit_i,
  input wire logic [3:0] busy_len_i,
  output logic busy_o,
  output logic [7:0] bad_o
);
  logic [3:0] left;
  logic in_sr;
  assign busy_o = left != 4'h0;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left <= 4'h0;
      in_sr <= 1'b0;
      bad_o <= 8'h0;
    end else begin
      // Grant stays high one edge after pending drops, so only an idle model starts
      if (grant_i && left == 4'h0) left <= busy_len_i;
      else if (left != 4'h0) left <= left - 4'h1;
      if ((enter_i && in_sr) || (exit_i && !in_sr)) bad_o <= bad_o + 8'h1;
      if (enter_i) in_sr <= 1'b1;
      if (exit_i) in_sr <= 1'b0;
    end
  end
endmodule

// ---- verification/ddr3_self_refresh_control_bench.sv ----
// Random and corner stimulus for the self-refresh sequencer.
// Assumes a shortened safe idle count.
`timescale 1ns/1ps
module ddr3_self_refresh_control_bench;
  import dsr_pkg::*;
  localparam int SAFE = 64;
  logic clock_i = 0, rst_n_i = 0, pend = 0, grant, ref_c, ent, ext, insr, busy;
  logic [2:0] mode = 3'h2;
  logic [3:0] code = 4'h0, blen = 4'h1;
  logic [7:0] bad;
  int n_fail = 0, num_checks = 0, seed = 5377, n_ref = 0, n_pair = 0, t;
  bit [DSR_WINDOW_CYC-1:0] rhist = '0;
  int rwin = 0;
  int rmax = 0;
  dsr_self_refresh_control #(.SAFE_IDLE_CYC(SAFE)) i_dsr_self_refresh_control (.clock_i, .rst_n_i,
    .low_power_select_i(mode), .self_refresh_idle_delay_i(code), .cmd_pending_i(pend), .cmd_busy_i(busy),
    .cmd_grant_o(grant), .refresh_cmd_o(ref_c), .sr_enter_o(ent), .sr_exit_o(ext), .in_self_refresh_o(insr));
  dsr_mem_model i_dsr_mem_model (.clock_i, .rst_n_i, .grant_i(grant), .enter_i(ent), .exit_i(ext),
    .busy_len_i(blen), .busy_o(busy), .bad_o(bad));
  initial forever #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    n_ref += ref_c;
    n_pair += ent + ext;
    // Refreshes seen in the last two refresh intervals, current edge included
    rwin = rwin + int'(ref_c === 1'b1) - int'(rhist[DSR_WINDOW_CYC-1]);
    rhist = {rhist[DSR_WINDOW_CYC-2:0], ref_c === 1'b1};
    if (rwin > rmax) rmax = rwin;
    if (ref_c === 1'b1) chk(rwin <= DSR_REF_LIMIT, "refresh window over limit");
  end
  ////////////////////
  function automatic int exp_idle(input logic [3:0] c);
    return c >= 4'h9 ? SAFE : 8 << c;
  endfunction
  function automatic logic sig(input int w);
    return w == 0 ? ent : w == 1 ? grant : w == 2 ? !busy : ext;
  endfunction
  task automatic wait_for(input int w, output int n);
    n = 0;
    while (sig(w) !== 1'b1 && n < 4000) begin
      @(posedge clock_i);
      #1 n++;
    end
    if (n >= 4000) chk(1'b0, "wait timed out");
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////
  initial begin
    #2ms n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge clock_i);
    #1 rst_n_i = 1;
    // Short delays first stress the window limiter; random doubling codes 0x0 to 0x8 next; the last quarter keeps the safe setting
    for (int i = 0; i < 24; i++) begin
      if (i < 12) code = 4'h0;
      else if (i < 18) code = 4'($unsigned($random(seed)) % 9);
      else code = 4'h9 + 4'($unsigned($random(seed)) % 7);
      blen = 4'($unsigned($random(seed)) % 15 + 1);
      wait_for(2, t);
      wait_for(0, t);
      chk(ent && t >= exp_idle(code), "entry timing");
      repeat (1 + $unsigned($random(seed)) % 8) @(posedge clock_i);
      #1 pend = 1;
      wait_for(1, t);
      chk(grant && !insr, "no grant after exit");
      @(posedge clock_i);
      #1 pend = 0;
    end
    wait_for(0, t);
    mode = 3'h0;
    wait_for(3, t);
    chk(ext, "no exit on mode leave");
    repeat (300) @(posedge clock_i);
    // 24 rounds plus the final entry, each one entry and one exit
    chk(!insr && n_ref === n_pair && n_pair === 50 && bad === 8'h0, "refresh pairing");
    chk(rmax == DSR_REF_LIMIT - 1, "window never filled");
    report_and_stop;
  end
endmodule
